/* shared/irq_enable_regs.svh */
// Purpose: offsets, bit positions, reset values of the interrupt enable block
// Assumes: axi4-lite byte addressing, 32-bit data
// Notes:   definitions only
`ifndef IRQ_ENABLE_REGS_SVH
`define IRQ_ENABLE_REGS_SVH

`define IEM_OFFSET         8'ha8
`define IEM_RESET          8'h00
`define IEM_WRITE_MASK     8'hdf
`define IEM_BIT_MASTER     7
`define IEM_BIT_SERIAL1    6
`define IEM_BIT_RESERVED   5
`define IEM_BIT_SERIAL0    4
`define IEM_BIT_TIMER1     3
`define IEM_BIT_PIN1       2
`define IEM_BIT_TIMER0     1
`define IEM_BIT_PIN0       0
`define IEM_NUM_SOURCES    6
`define IEM_NUM_WIDTH      4
`define IEM_NUM_PIN0       4'h0
`define IEM_NUM_TIMER0     4'h1
`define IEM_NUM_PIN1       4'h2
`define IEM_NUM_TIMER1     4'h3
`define IEM_NUM_SERIAL0    4'h4
`define IEM_NUM_SERIAL1    4'h7
`define AXI_RESP_OKAY      2'h0
`define AXI_RESP_SLVERR    2'h2

`endif

/* shared/irq_enable_pkg.sv */
// Purpose: types of the interrupt enable block
// Assumes: constants live in irq_enable_regs.svh
// Notes:   source order is fixed priority order, lowest number first
package irq_enable_pkg;

    // pending request lines, index = position in priority order
    typedef struct packed {
        logic serial_port1;
        logic serial_port0;
        logic timer1;
        logic pin_irq1;
        logic timer0;
        logic pin_irq0;
    } irq_sources_t;

    // request offered to the core
    typedef struct packed {
        logic       valid;
        logic [3:0] number;
    } irq_request_t;

endpackage

/* core/interrupt_enable_mask.sv */
// Purpose: interrupt enable register with master gate and fixed-order pick
// Assumes: source requests are synchronous to aclk and held until serviced
// Notes:   register reached over axi4-lite; only byte lane 0 is used
`timescale 1ns/1ps
`include "irq_enable_regs.svh"

// Function
// R01 - bit 7 is master enable; cleared means nothing reaches the core
// R02 - a request passes only when master and its own enable are 1
// R03 - own enable 0 masks the source, 1 unmasks it under master
// R04 - bit 6 enables the second serial port interrupt
// R05 - bit 4 enables the first serial port interrupt
// R06 - bit 3 enables the timer 1 interrupt
// R07 - bit 2 enables external interrupt input 1
// R08 - bit 1 enables the timer 0 interrupt
// R09 - bit 0 enables external interrupt input 0
// R10 - among simultaneous enabled requests the lowest interrupt number wins
// R11 - reset clears all bits; bit 5 reads 0 and ignores writes
module interrupt_enable_mask
(
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [7:0]                   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [7:0]                   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire irq_enable_pkg::irq_sources_t irq_pending,
    output irq_enable_pkg::irq_sources_t      irq_gated,
    output irq_enable_pkg::irq_request_t      irq_request
);

    logic [7:0]                   enable_reg;
    logic [7:0]                   enable_next;
    logic                         aw_held_reg;
    logic                         aw_held_next;
    logic [7:0]                   aw_addr_reg;
    logic [7:0]                   aw_addr_next;
    logic                         w_held_reg;
    logic                         w_held_next;
    logic [31:0]                  w_data_reg;
    logic [31:0]                  w_data_next;
    logic [3:0]                   w_strb_reg;
    logic [3:0]                   w_strb_next;
    logic                         bvalid_reg;
    logic                         bvalid_next;
    logic [1:0]                   bresp_reg;
    logic [1:0]                   bresp_next;
    logic                         rvalid_reg;
    logic                         rvalid_next;
    logic [31:0]                  rdata_reg;
    logic [31:0]                  rdata_next;
    logic [1:0]                   rresp_reg;
    logic [1:0]                   rresp_next;
    irq_enable_pkg::irq_sources_t gated_reg;
    irq_enable_pkg::irq_sources_t gated_next;
    irq_enable_pkg::irq_request_t request_reg;
    irq_enable_pkg::irq_request_t request_next;
    logic                         aw_take;
    logic                         w_take;
    logic                         do_write;
    logic [7:0]                   lane_mask;
    logic                         awready_reg;
    logic                         awready_next;
    logic                         wready_reg;
    logic                         wready_next;
    logic                         arready_reg;
    logic                         arready_next;
    logic                         ar_take;
    logic [`IEM_NUM_SOURCES-1:0]  source_pass;

    function automatic logic hits_enable(input logic [7:0] addr);
        hits_enable = (addr == `IEM_OFFSET);
    endfunction

    // readies are flops, so a handshake lands on the edge after ready was raised
    assign aw_take  = s_axi_awvalid && awready_reg;
    assign w_take   = s_axi_wvalid && wready_reg;
    assign ar_take  = s_axi_arvalid && arready_reg;
    // write commits once both halves are in and the previous response is gone
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign lane_mask = w_strb_reg[0] ? `IEM_WRITE_MASK : 8'h00;

    // write channel and enable register
    always_comb
    begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next  = w_held_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        enable_next  = enable_reg;
        // ready drops on the take, so one held item never gets overwritten
        awready_next = 1'b0;
        wready_next  = 1'b0;
        if (s_axi_awvalid && !aw_held_reg && !awready_reg)
        begin
            awready_next = 1'b1;
        end
        if (s_axi_wvalid && !w_held_reg && !wready_reg)
        begin
            wready_next = 1'b1;
        end
        if (aw_take)
        begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (w_take)
        begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready)
        begin
            bvalid_next = 1'b0;
        end
        if (do_write)
        begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            if (hits_enable(aw_addr_reg))
            begin
                // reserved bit 5 never stored, so it always reads 0 [R11]
                enable_next = (enable_reg & ~lane_mask) | (w_data_reg[7:0] & lane_mask);
                bresp_next  = `AXI_RESP_OKAY;
            end
            else
            begin
                bresp_next = `AXI_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_reg  <= `IEM_RESET; // [R11]
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
        end
        else
        begin
            enable_reg  <= enable_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg  <= w_held_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
        end
    end

    // read channel
    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next = 1'b0;
        end
        // arready waits until the previous answer is gone; one read in flight
        arready_next = 1'b0;
        if (s_axi_arvalid && !rvalid_reg && !arready_reg)
        begin
            arready_next = 1'b1;
        end
        if (ar_take)
        begin
            rvalid_next = 1'b1;
            if (hits_enable(s_axi_araddr))
            begin
                rdata_next = {24'h00_0000, enable_reg};
                rresp_next = `AXI_RESP_OKAY;
            end
            else
            begin
                rdata_next = 32'h0000_0000;
                rresp_next = `AXI_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= 2'h0;
        end
        else
        begin
            rvalid_reg <= rvalid_next;
            arready_reg <= arready_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    // which register bit enables each source line; bit 5 has no source
    function automatic int unsigned source_enable_bit(input int unsigned idx);
        case (idx)
            0:       source_enable_bit = `IEM_BIT_PIN0;    // [R09]
            1:       source_enable_bit = `IEM_BIT_TIMER0;  // [R08]
            2:       source_enable_bit = `IEM_BIT_PIN1;    // [R07]
            3:       source_enable_bit = `IEM_BIT_TIMER1;  // [R06]
            4:       source_enable_bit = `IEM_BIT_SERIAL0; // [R05]
            default: source_enable_bit = `IEM_BIT_SERIAL1; // [R04]
        endcase
    endfunction

    // master and own enable are both needed for a line to pass
    genvar g;
    generate
        for (g = 0; g < `IEM_NUM_SOURCES; g = g + 1)
        begin : gate_gen
            assign source_pass[g] = enable_reg[`IEM_BIT_MASTER] // [R01] [R02] [R03]
                && enable_reg[source_enable_bit(g)] && irq_pending[g];
        end
    endgenerate

    // gating and fixed-order pick; registered so outputs lag requests by one cycle
    always_comb
    begin
        gated_next          = source_pass;
        request_next.valid  = |gated_next; // [R01]
        // lowest fixed number first; serial port 1 carries number 7 [R10]
        if (gated_next.pin_irq0)
            request_next.number = `IEM_NUM_PIN0;
        else if (gated_next.timer0)
            request_next.number = `IEM_NUM_TIMER0;
        else if (gated_next.pin_irq1)
            request_next.number = `IEM_NUM_PIN1;
        else if (gated_next.timer1)
            request_next.number = `IEM_NUM_TIMER1;
        else if (gated_next.serial_port0)
            request_next.number = `IEM_NUM_SERIAL0;
        else if (gated_next.serial_port1)
            request_next.number = `IEM_NUM_SERIAL1;
        else
            request_next.number = `IEM_NUM_PIN0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gated_reg   <= '0;
            request_reg <= '0;
        end
        else
        begin
            gated_reg   <= gated_next;
            request_reg <= request_next;
        end
    end

    // every output below is a flop; no path from an input reaches a pin
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign irq_gated     = gated_reg;
    assign irq_request   = request_reg;

endmodule

/* bench/iem_checker_assertions.sv */
// Purpose: port-level checker for interrupt_enable_mask
// Assumes: one clock, synchronous active-low reset
// Notes:   enable register is not visible here, so gating is checked against pending
`timescale 1ns/1ps
module iem_checker
(
    input wire logic                         aclk,
    input wire logic                         aresetn,
    input wire logic                         s_axi_awvalid,
    input wire logic                         s_axi_awready,
    input wire logic                         s_axi_bvalid,
    input wire logic                         s_axi_bready,
    input wire logic                         s_axi_arvalid,
    input wire logic                         s_axi_arready,
    input wire logic                         s_axi_rvalid,
    input wire logic                         s_axi_rready,
    input wire logic [31:0]                  s_axi_rdata,
    input wire irq_enable_pkg::irq_sources_t irq_pending,
    input wire irq_enable_pkg::irq_sources_t irq_gated,
    input wire irq_enable_pkg::irq_request_t irq_request
);
    logic [3:0] low_num;
    // lowest set gated line wins; line 5 carries number 7
    always_comb
    begin
        low_num = 4'h7;
        for (int i = 4; i >= 0; i--)
            if (irq_gated[i]) low_num = 4'(i);
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    gate_subset_a: assert property ((irq_gated & ~$past(irq_pending)) == 6'h00)
        else $error("gated line without pending request");
    req_valid_a: assert property (irq_request.valid == (irq_gated != 6'h00))
        else $error("request valid disagrees with gated lines");
    pick_low_a: assert property (irq_request.valid |-> irq_request.number == low_num)
        else $error("request number is not the lowest gated source");
    b_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before bready");
    r_stands_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before rready");
    ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not one cycle after address");
    rdata_zero_a: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[5])
        else $error("upper or reserved read bits set");
    reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> irq_gated == 6'h00
        && !irq_request.valid && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not cleared by reset");
    cover property (s_axi_awvalid && s_axi_awready);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (irq_request.valid && irq_request.number == 4'h7);
endmodule
bind interrupt_enable_mask iem_checker chk_u (.*);

/* bench/core_ack_model.sv */
// Purpose: core side that accepts offered interrupt requests
// Assumes: request is a level, taken on any edge where valid is high
// Notes:   keeps only the number last taken, for the bench to inspect
`timescale 1ns/1ps
module core_ack_model
(
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire irq_enable_pkg::irq_request_t irq_request,
    output logic [3:0]                        taken_num
);
    always_ff @(posedge aclk)
    begin
        if (!aresetn) taken_num <= 4'hf;
        else if (irq_request.valid) taken_num <= irq_request.number;
    end
endmodule

/* bench/interrupt_enable_mask_tb_top.sv */
// Purpose: self-checking bench for interrupt_enable_mask
// Assumes: 50 MHz aclk, reset held three cycles
// Notes:   random enable and pending patterns plus single-source corners
`timescale 1ns/1ps
`include "irq_enable_regs.svh"
module interrupt_enable_mask_tb_top;
    logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd;
    logic [3:0] ws, tn;
    logic [1:0] bresp, rresp, rs;
    logic [5:0] pend, gated;
    irq_enable_pkg::irq_request_t req;
    integer err_count = 0, cmp_count = 0, seed = 34, i;
    logic [7:0] e;
    interrupt_enable_mask dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .irq_pending(pend), .irq_gated(gated), .irq_request(req));
    core_ack_model core_u (.aclk(aclk), .aresetn(aresetn), .irq_request(req), .taken_num(tn));
    initial
    begin
        aclk = 0;
        forever #10 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [5:0] gate(input logic [7:0] en, input logic [5:0] p);
        return p & {en[6], en[4], en[3], en[2], en[1], en[0]} & {6{en[7]}};
    endfunction
    function automatic logic [3:0] pick(input logic [5:0] g);
        for (int k = 0; k < 5; k++) if (g[k]) return 4'(k);
        return 4'h7;
    endfunction
    // write holds each channel until its own handshake, bready until bvalid
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge aclk);
        awa <= a;
        wd  <= d;
        ws  <= s;
        awv <= 1;
        wv  <= 1;
        br  <= 1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awv && awr) awv <= 0;
            if (wv && wr) wv <= 0;
            if (bv) break;
        end
        br <= 0;
        rs = bresp;
        if (n == 50)
        begin
            err_count++;
            end_of_test();
        end
    endtask
    task automatic rd_reg(input logic [7:0] a);
        int n;
        @(posedge aclk);
        ara <= a;
        arv <= 1;
        rr  <= 1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arv && arr) arv <= 0;
            if (rv) break;
        end
        rr <= 0;
        e = rd[7:0];
        rs = rresp;
        if (n == 50)
        begin
            err_count++;
            end_of_test();
        end
    endtask
    // enable then pending, three edges so the one-cycle lag has landed
    task automatic irq_case(input logic [7:0] en, input logic [5:0] p);
        wr_reg(`IEM_OFFSET, {24'h0, en}, 4'h1);
        pend <= p;
        repeat (3) @(posedge aclk);
        chk(gated, gate(en, p));
        chk(req.valid, gate(en, p) != 6'h00);
        if (gate(en, p) != 6'h00) chk(req.number, pick(gate(en, p)));
    endtask
    initial
    begin
        {awv, wv, br, arv, rr} = 0;
        awa = 0; ara = 0; wd = 0; ws = 0; pend = 0; aresetn = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rd_reg(`IEM_OFFSET);
        chk(e, `IEM_RESET);
        wr_reg(`IEM_OFFSET, 32'hffff_ffff, 4'hf);
        chk(rs, `AXI_RESP_OKAY);
        rd_reg(`IEM_OFFSET);
        chk(e, 8'hdf);
        chk(rs, `AXI_RESP_OKAY);
        // wstrb lane 0 off leaves the register alone
        wr_reg(`IEM_OFFSET, 32'h0000_0000, 4'he);
        rd_reg(`IEM_OFFSET);
        chk(e, 8'hdf);
        wr_reg(8'h10, 32'h0, 4'hf);
        chk(rs, `AXI_RESP_SLVERR);
        rd_reg(8'h10);
        chk(rs, `AXI_RESP_SLVERR);
        chk(e, 8'h00);
        // an unmapped write must not touch the register
        rd_reg(`IEM_OFFSET);
        chk(e, 8'hdf);
        irq_case(8'h7f, 6'h3f);
        irq_case(8'h80, 6'h3f);
        // one source at a time, mapped bit by bit; bit 5 has no source
        for (i = 0; i < 7; i++)
        begin
            if (i != 5)
            begin
                irq_case(8'h80 | (8'h01 << i), 6'h3f);
            end
        end
        irq_case(8'hdf, 6'h3f);
        chk(tn, 4'h0);
        for (i = 0; i < 30; i++) irq_case(8'($random(seed)), 6'($random(seed)));
        // park a nonzero enable so the mid-run reset has something to clear
        wr_reg(`IEM_OFFSET, 32'h0000_009f, 4'h1);
        aresetn <= 0;
        @(posedge aclk);
        aresetn <= 1;
        rd_reg(`IEM_OFFSET);
        chk(e, `IEM_RESET);
        chk(gated, 6'h00);
        end_of_test();
    end
endmodule
